// >>> rtl/incl_output_map.svh
// register offsets, limits, reset values and timing counts of the output stage
`ifndef INCL_OUTPUT_MAP_SVH
`define INCL_OUTPUT_MAP_SVH
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_CUTOFF 8'h04
`define OFS_GYRO 8'h08
`define OFS_RSTART 8'h0C
`define OFS_REND 8'h10
`define OFS_THR_A 8'h14
`define OFS_HOLD 8'h18
`define OFS_THR_B 8'h1C
`define OFS_DELAY 8'h20
`define OFS_STATUS 8'h24
`define OFS_LP_VAL 8'h28
`define OFS_FUS_VAL 8'h2C
`define OFS_OFFSET 8'h30
// ctrl fields
`define CTRL_TYPE_LSB 0
`define CTRL_SRC_BIT 2
`define CTRL_ZERO_BIT 3
// status fields
`define STAT_SW_BIT 0
`define STAT_ERR_BIT 1
// limits in 0.01 units (hz, deg, ms), gyro weight in percent
`define CUTOFF_MIN 16'sh001E
`define CUTOFF_MAX 16'sh0190
`define GYRO_MAX 16'sh0064
`define ANGLE_MIN 16'shB9B0
`define ANGLE_MAX 16'sh4650
`define ZERO_DEG 16'sh0000
`define SPAN_MIN 16'sh0064
`define SPAN_MAX 17'h08E0C
`define PARAM_MAX 16'sh270F
// reset values
`define RST_CUTOFF 16'sh0190
`define RST_GYRO 16'sh0064
`define RST_RSTART 16'shB9B0
`define RST_REND 16'sh4650
`define RST_ZERO 16'sh0000
// time base: one tick is 0.01 ms
`define TICK_NS 10000
`define CLK_NS 4
`define TICK_CYC (`TICK_NS / `CLK_NS)
`define CODE_FULL 16'hFFFF
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// >>> rtl/incl_output_pkg.sv
// types shared by the inclination output stage
package incl_output_pkg;
    // output type selection
    typedef enum logic [1:0] {
        OUT_OFF, OUT_CURRENT, OUT_VOLTAGE, OUT_SWITCH
    } out_type_t;
    // switching output state
    typedef enum logic {
        SW_IDLE, SW_ACTIVE
    } sw_state_t;
    // both filter results for one sample, 0.01 deg signed
    typedef struct packed {
        logic signed [15:0] lp;
        logic signed [15:0] fus;
    } angles_t;
    // settings that steer the filters
    typedef struct packed {
        logic [15:0] cutoff;
        logic [15:0] gyro;
    } filt_cfg_t;
endpackage

// >>> rtl/range_scaler.sv
// sequential divider mapping a position in the range onto a full scale code
`include "incl_output_map.svh"
module range_scaler (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_start,
    input wire logic [16:0] i_num,
    input wire logic [16:0] i_den,
    output logic [15:0] o_code,
    output logic o_done
);
    logic [32:0] rem, next_rem;      // partial remainder
    logic [15:0] quo, next_quo;      // quotient bits so far
    logic [4:0] cnt, next_cnt;       // bits left to produce
    logic [15:0] code, next_code;
    logic done, next_done;
    logic [33:0] trial;
    // =======================================
    // one quotient bit per clock
    always_comb begin
        next_rem = rem;
        next_quo = quo;
        next_cnt = cnt;
        next_code = code;
        next_done = 1'b0;
        trial = {rem, 1'b0} - {17'h0_0000, i_den};
        if (i_start) begin
            // position equal to span gives full scale
            next_rem = {16'h0000, i_num};
            next_quo = 16'h0000;
            next_cnt = 5'h10;
        end else if (cnt != 5'h00) begin
            if (!trial[33]) begin
                next_rem = trial[32:0];
                next_quo = {quo[14:0], 1'b1};
            end else begin
                next_rem = {rem[31:0], 1'b0};
                next_quo = {quo[14:0], 1'b0};
            end
            next_cnt = cnt - 5'h01;
            if (cnt == 5'h01) begin
                next_done = 1'b1;
                next_code = (i_num >= i_den) ? `CODE_FULL : next_quo;
            end
        end
    end
    // registers of the divider
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rem <= 33'h0_0000_0000;
            quo <= 16'h0000;
            cnt <= 5'h00;
            code <= 16'h0000;
            done <= 1'b0;
        end else begin
            rem <= next_rem;
            quo <= next_quo;
            cnt <= next_cnt;
            code <= next_code;
            done <= next_done;
        end
    end
    assign o_code = code;
    assign o_done = done;
endmodule

// >>> rtl/incl_output_stage.sv
// output stage: zeroing, range scaling, switching output and register slave
//
// Summary of operation
// - cutoff accepted only 0.3 to 4 Hz
// - gyro weighting accepted only 0 to 100 percent
// - zero command captures angle as offset
// - range start -180..0, end -180..180
// - range end below start is refused
// - span scaled onto range, sensitivity bounded
// - at most one output type drives output, none with OUT_OFF
// - analog source selects low-pass or fusion
// - switch goes active above threshold A
// - active held at least min hold time
// - release after continuous below-B release delay
// - both filter results always readable
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`include "incl_output_map.svh"
module incl_output_stage (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire incl_output_pkg::angles_t i_angles,
    input wire logic i_sample,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output incl_output_pkg::filt_cfg_t o_filt_cfg,
    output incl_output_pkg::out_type_t o_out_type,
    output logic [15:0] o_aout_code,
    output logic o_switch
);
    // =======================================
    // helpers
    // true when v lies within lo..hi, signed
    function automatic logic in_lim(input logic signed [15:0] v, input logic signed [15:0] lo,
                                    input logic signed [15:0] hi);
        in_lim = (v >= lo) && (v <= hi);
    endfunction
    // difference of two angles at one more bit
    function automatic logic signed [16:0] sdiff(input logic signed [15:0] a, input logic signed [15:0] b);
        sdiff = 17'(a) - 17'(b);
    endfunction
    // =======================================
    // settings and bus state
    incl_output_pkg::out_type_t out_type, next_out_type; // active output type
    logic src_fus, next_src_fus;                        // analog source select
    logic signed [15:0] cutoff, next_cutoff;            // 0.01 hz
    logic signed [15:0] gyro, next_gyro;                // percent
    logic signed [15:0] rstart, next_rstart;            // 0.01 deg
    logic signed [15:0] rend, next_rend;
    logic signed [15:0] thr_a, next_thr_a;
    logic signed [15:0] thr_b, next_thr_b;
    logic signed [15:0] hold, next_hold;                // 0.01 ms
    logic signed [15:0] delay, next_delay;
    logic signed [15:0] offset, next_offset;            // zero point
    logic cfg_err, next_cfg_err;                        // sticky refusal
    logic aw_rdy, next_aw_rdy;
    logic b_vld, next_b_vld;
    logic [1:0] b_resp, next_b_resp;
    logic ar_rdy, next_ar_rdy;
    logic r_vld, next_r_vld;
    logic [31:0] r_data, next_r_data;
    logic [1:0] r_resp, next_r_resp;
    logic wr_go, rd_go, wr_bad;
    logic signed [15:0] wv;                             // low half of write data
    logic signed [15:0] sel_ang;                        // chosen source
    logic signed [16:0] span;
    assign wr_go = aw_rdy && i_awvalid && i_wvalid;
    assign rd_go = ar_rdy && i_arvalid;
    assign wv = i_wdata[15:0];
    // offered angle of the selected source
    assign sel_ang = src_fus ? i_angles.fus : i_angles.lp;
    // =======================================
    // register writes, refused values keep the old setting
    always_comb begin
        next_out_type = out_type;
        next_src_fus = src_fus;
        next_cutoff = cutoff;
        next_gyro = gyro;
        next_rstart = rstart;
        next_rend = rend;
        next_thr_a = thr_a;
        next_thr_b = thr_b;
        next_hold = hold;
        next_delay = delay;
        next_offset = offset;
        next_cfg_err = cfg_err;
        wr_bad = 1'b0;
        span = 17'h0_0000;
        if (wr_go && (i_wstrb != 4'h0)) begin
            unique case (i_awaddr)
                `OFS_CTRL: begin
                    next_out_type = incl_output_pkg::out_type_t'(i_wdata[`CTRL_TYPE_LSB +: 2]);
                    next_src_fus = i_wdata[`CTRL_SRC_BIT];
                    if (i_wdata[`CTRL_ZERO_BIT]) begin
                        next_offset = sel_ang;
                    end
                end
                `OFS_CUTOFF: begin
                    if (in_lim(wv, `CUTOFF_MIN, `CUTOFF_MAX)) next_cutoff = wv;
                    else wr_bad = 1'b1;
                end
                `OFS_GYRO: begin
                    if (in_lim(wv, `ZERO_DEG, `GYRO_MAX)) next_gyro = wv;
                    else wr_bad = 1'b1;
                end
                `OFS_RSTART: begin
                    span = sdiff(rend, wv);
                    // start window and end not below start, span bounds sensitivity
                    if (in_lim(wv, `ANGLE_MIN, `ZERO_DEG) && span >= 17'(`SPAN_MIN)) begin
                        next_rstart = wv;
                    end else wr_bad = 1'b1;
                end
                `OFS_REND: begin
                    span = sdiff(wv, rstart);
                    if (in_lim(wv, `ANGLE_MIN, `ANGLE_MAX) && span >= 17'(`SPAN_MIN)) begin
                        next_rend = wv;
                    end else wr_bad = 1'b1;
                end
                `OFS_THR_A: begin
                    if (in_lim(wv, `ZERO_DEG, `PARAM_MAX)) next_thr_a = wv;
                    else wr_bad = 1'b1;
                end
                `OFS_HOLD: begin
                    if (in_lim(wv, `ZERO_DEG, `PARAM_MAX)) next_hold = wv;
                    else wr_bad = 1'b1;
                end
                `OFS_THR_B: begin
                    if (in_lim(wv, `ZERO_DEG, `PARAM_MAX)) next_thr_b = wv;
                    else wr_bad = 1'b1;
                end
                `OFS_DELAY: begin
                    if (in_lim(wv, `ZERO_DEG, `PARAM_MAX)) next_delay = wv;
                    else wr_bad = 1'b1;
                end
                `OFS_STATUS: begin
                    // write one clears the refusal flag
                    if (i_wdata[`STAT_ERR_BIT]) next_cfg_err = 1'b0;
                end
                default: wr_bad = 1'b1;
            endcase
        end
        // a refusal in the clearing cycle still sets the flag
        if (wr_bad) next_cfg_err = 1'b1;
    end
    // =======================================
    // bus handshake: both write channels taken in one cycle
    always_comb begin
        next_aw_rdy = 1'b0;
        next_b_vld = b_vld;
        next_b_resp = b_resp;
        next_ar_rdy = 1'b0;
        next_r_vld = r_vld;
        next_r_data = r_data;
        next_r_resp = r_resp;
        if (!aw_rdy && !b_vld && i_awvalid && i_wvalid) next_aw_rdy = 1'b1;
        if (wr_go) begin
            next_b_vld = 1'b1;
            next_b_resp = wr_bad ? `RESP_SLVERR : `RESP_OKAY;
        end else if (b_vld && i_bready) begin
            next_b_vld = 1'b0;
        end
        if (!ar_rdy && !r_vld && i_arvalid) next_ar_rdy = 1'b1;
        if (rd_go) begin
            next_r_vld = 1'b1;
            next_r_resp = `RESP_OKAY;
            unique case (i_araddr)
                `OFS_CTRL: next_r_data = {28'h000_0000, 1'b0, src_fus, out_type};
                `OFS_CUTOFF: next_r_data = {16'h0000, cutoff};
                `OFS_GYRO: next_r_data = {16'h0000, gyro};
                `OFS_RSTART: next_r_data = {16'h0000, rstart};
                `OFS_REND: next_r_data = {16'h0000, rend};
                `OFS_THR_A: next_r_data = {16'h0000, thr_a};
                `OFS_HOLD: next_r_data = {16'h0000, hold};
                `OFS_THR_B: next_r_data = {16'h0000, thr_b};
                `OFS_DELAY: next_r_data = {16'h0000, delay};
                `OFS_STATUS: next_r_data = {30'h0000_0000, cfg_err, o_switch};
                `OFS_LP_VAL: next_r_data = {16'h0000, i_angles.lp};
                `OFS_FUS_VAL: next_r_data = {16'h0000, i_angles.fus};
                `OFS_OFFSET: next_r_data = {16'h0000, offset};
                default: begin
                    next_r_data = 32'h0000_0000;
                    next_r_resp = `RESP_SLVERR;
                end
            endcase
        end else if (r_vld && i_rready) begin
            next_r_vld = 1'b0;
        end
    end
    // settings and bus registers
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            out_type <= incl_output_pkg::OUT_OFF;
            src_fus <= 1'b0;
            cutoff <= `RST_CUTOFF;
            gyro <= `RST_GYRO;
            rstart <= `RST_RSTART;
            rend <= `RST_REND;
            thr_a <= `RST_ZERO;
            thr_b <= `RST_ZERO;
            hold <= `RST_ZERO;
            delay <= `RST_ZERO;
            offset <= `RST_ZERO;
            cfg_err <= 1'b0;
            aw_rdy <= 1'b0;
            b_vld <= 1'b0;
            b_resp <= `RESP_OKAY;
            ar_rdy <= 1'b0;
            r_vld <= 1'b0;
            r_data <= 32'h0000_0000;
            r_resp <= `RESP_OKAY;
        end else begin
            out_type <= next_out_type;
            src_fus <= next_src_fus;
            cutoff <= next_cutoff;
            gyro <= next_gyro;
            rstart <= next_rstart;
            rend <= next_rend;
            thr_a <= next_thr_a;
            thr_b <= next_thr_b;
            hold <= next_hold;
            delay <= next_delay;
            offset <= next_offset;
            cfg_err <= next_cfg_err;
            aw_rdy <= next_aw_rdy;
            b_vld <= next_b_vld;
            b_resp <= next_b_resp;
            ar_rdy <= next_ar_rdy;
            r_vld <= next_r_vld;
            r_data <= next_r_data;
            r_resp <= next_r_resp;
        end
    end
    // =======================================
    // analog path: zeroed angle clamped into the range, then divided
    logic signed [16:0] zeroed;                         // angle minus offset
    logic signed [17:0] pos;                            // position in range
    logic [16:0] num;
    logic [15:0] code;
    logic code_done;
    assign zeroed = sdiff(sel_ang, offset);
    assign pos = 18'(zeroed) - 18'(rstart);
    assign num = pos[17] ? 17'h0_0000 : pos[16:0];
    range_scaler u_scaler (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_start(i_sample),
        .i_num(num),
        .i_den(17'(sdiff(rend, rstart))),
        .o_code(code),
        .o_done(code_done)
    );
    // =======================================
    // switching output
    incl_output_pkg::sw_state_t sw, next_sw;
    logic [15:0] hold_cnt, next_hold_cnt;               // ticks of hold left
    logic [15:0] rel_cnt, next_rel_cnt;                 // ticks spent below B
    logic below, next_below;                            // last sample under B
    logic [11:0] pre, next_pre;                         // tick prescaler
    logic tick, below_now;
    assign tick = (pre == 12'(`TICK_CYC - 1));
    assign below_now = i_sample ? (zeroed < 17'(thr_b)) : below;
    // next state of the switching machine
    always_comb begin
        next_sw = sw;
        next_hold_cnt = hold_cnt;
        next_rel_cnt = rel_cnt;
        next_below = below_now;
        next_pre = tick ? 12'h000 : pre + 12'h001;
        if (tick && hold_cnt != 16'h0000) next_hold_cnt = hold_cnt - 16'h0001;
        if (!below_now) next_rel_cnt = 16'h0000;
        else if (tick && rel_cnt != 16'hFFFF) next_rel_cnt = rel_cnt + 16'h0001;
        unique case (sw)
            incl_output_pkg::SW_IDLE: begin
                if (i_sample && zeroed > 17'(thr_a)) begin
                    next_sw = incl_output_pkg::SW_ACTIVE;
                    // one extra tick: the prescaler runs free, so the first tick may come at once
                    next_hold_cnt = (hold == `RST_ZERO) ? 16'h0000 : 16'(hold) + 16'h0001;
                    next_rel_cnt = 16'h0000;
                end
            end
            incl_output_pkg::SW_ACTIVE: begin
                // first tick below b may be partial, so a nonzero delay needs one tick more
                if (hold_cnt == 16'h0000 && below_now
                    && (delay == `RST_ZERO || rel_cnt > 16'(delay))) begin
                    next_sw = incl_output_pkg::SW_IDLE;
                end
            end
        endcase
    end
    // registers of the switching machine and the outputs
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sw <= incl_output_pkg::SW_IDLE;
            hold_cnt <= 16'h0000;
            rel_cnt <= 16'h0000;
            below <= 1'b0;
            pre <= 12'h000;
            o_switch <= 1'b0;
            o_aout_code <= 16'h0000;
            o_out_type <= incl_output_pkg::OUT_OFF;
            o_filt_cfg <= '0;
        end else begin
            sw <= next_sw;
            hold_cnt <= next_hold_cnt;
            rel_cnt <= next_rel_cnt;
            below <= next_below;
            pre <= next_pre;
            // switch only drives in switching mode
            o_switch <= (out_type == incl_output_pkg::OUT_SWITCH) && (next_sw == incl_output_pkg::SW_ACTIVE);
            if (out_type == incl_output_pkg::OUT_CURRENT || out_type == incl_output_pkg::OUT_VOLTAGE) begin
                if (code_done) o_aout_code <= code;
            end else begin
                o_aout_code <= 16'h0000;
            end
            o_out_type <= out_type;
            o_filt_cfg <= {cutoff, gyro};
        end
    end
    assign o_awready = aw_rdy;
    assign o_wready = aw_rdy;
    assign o_bvalid = b_vld;
    assign o_bresp = b_resp;
    assign o_arready = ar_rdy;
    assign o_rvalid = r_vld;
    assign o_rdata = r_data;
    assign o_rresp = r_resp;
    // =======================================
    // checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    // filter output lags the register by one edge, so skip the first edge after reset
    AST_CUTOFF_LIM: assert property ($past(i_arst_n) |->
        o_filt_cfg.cutoff >= 16'(`CUTOFF_MIN) && o_filt_cfg.cutoff <= 16'(`CUTOFF_MAX))
        else $error("cutoff left its window");
    AST_GYRO_LIM: assert property (gyro <= `GYRO_MAX && gyro >= `ZERO_DEG)
        else $error("gyro weight out of range");
    AST_ZERO: assert property (wr_go && i_awaddr == `OFS_CTRL && i_wdata[`CTRL_ZERO_BIT] && i_wstrb != 4'h0
        |=> offset == $past(sel_ang)) else $error("zero command lost");
    AST_START_LIM: assert property (rstart <= `ZERO_DEG && rstart >= `ANGLE_MIN)
        else $error("range start out of bounds");
    AST_ORDER: assert property (sdiff(rend, rstart) >= 17'(`SPAN_MIN))
        else $error("range end below start");
    AST_CODE: assert property (code_done && out_type == incl_output_pkg::OUT_VOLTAGE
        && $past(out_type) == incl_output_pkg::OUT_VOLTAGE |=> o_aout_code == $past(code))
        else $error("analog code not updated");
    AST_ONE_TYPE: assert property (o_switch |-> o_out_type == incl_output_pkg::OUT_SWITCH)
        else $error("switch driven outside switch mode");
    AST_SET: assert property (sw == incl_output_pkg::SW_IDLE && i_sample && zeroed > 17'(thr_a)
        |=> sw == incl_output_pkg::SW_ACTIVE) else $error("switch did not set");
    AST_HOLD: assert property ($rose(sw) && hold != `RST_ZERO |=> sw == incl_output_pkg::SW_ACTIVE [*8])
        else $error("hold time cut short");
    AST_RELEASE: assert property (sw == incl_output_pkg::SW_ACTIVE && !below_now
        |=> sw == incl_output_pkg::SW_ACTIVE) else $error("released while above B");
    AST_READ_FUS: assert property (rd_go && i_araddr == `OFS_FUS_VAL
        |=> r_data[15:0] == $past(i_angles.fus))
        else $error("fusion result not reported");
    COV_SET: cover property ($rose(sw));
    COV_RELEASE: cover property ($fell(sw));
    COV_REFUSE: cover property (wr_go && wr_bad);
    COV_ZERO: cover property (wr_go && i_awaddr == `OFS_CTRL && i_wdata[`CTRL_ZERO_BIT]);
endmodule

// >>> tb/angle_source.sv
// sample source model feeding filter results
module angle_source (
    input wire logic i_clk_sys,
    input wire logic i_go,
    input wire logic [31:0] i_val,
    output incl_output_pkg::angles_t o_angles,
    output logic o_sample
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // one-cycle strobe, filter result held
    initial begin
        o_angles = '0;
        o_sample = 1'b0;
    end
    always @(posedge i_clk_sys) begin
        o_sample <= i_go;
        if (i_go) begin
            o_angles <= i_val;
        end
    end
endmodule

// >>> tb/tb.sv
// self-checking bench of the inclination output stage
`include "incl_output_map.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // design pins, named as the ports
    logic i_clk_sys = 1'b0, i_arst_n = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0;
    logic i_arvalid = 1'b0, i_bready = 1'b1, i_rready = 1'b1, go = 1'b0;
    logic i_sample, o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_switch;
    logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000, val = 32'h0000_0000, o_rdata;
    logic [3:0] i_wstrb = 4'hF, hsv;
    logic [1:0] o_bresp, o_rresp;
    logic [15:0] o_aout_code;
    incl_output_pkg::angles_t i_angles;
    incl_output_pkg::filt_cfg_t o_filt_cfg;
    incl_output_pkg::out_type_t o_out_type;
    localparam logic [1:0] OK = `RESP_OKAY;
    localparam logic [1:0] ER = `RESP_SLVERR;
    // corner samples at threshold a and b
    localparam logic signed [15:0] CORNER [4] = '{16'sh03E8, 16'sh03E9, 16'sh0320, 16'sh031F};
    integer seed = 32'h0000_D61D;
    int fails = 0, total_checks = 0, n;
    logic st = 1'b0;
    logic signed [15:0] v;
    assign hsv = {o_rvalid, o_arready, o_bvalid, o_awready};
    always #2 i_clk_sys = ~i_clk_sys;
    angle_source u_src (.i_clk_sys, .i_go(go), .i_val(val), .o_angles(i_angles), .o_sample(i_sample));
    incl_output_stage u_dut (.i_clk_sys, .i_arst_n, .i_angles, .i_sample, .i_awvalid, .o_awready,
        .i_awaddr, .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid,
        .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .o_filt_cfg, .o_out_type,
        .o_aout_code, .o_switch);
    // ==========
    // verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // exact four-state compare
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // bounded wait on a handshake flag
    task automatic hs(input int k);
        for (n = 0; n < 64 && hsv[k] !== 1'b1; n++) @(posedge i_clk_sys);
        if (n < 64) return;
        fails++;
        final_report();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        hs(0);
        chk("wready", 32'h0000_0001, o_wready);
        i_awvalid <= 1'b0;
        i_wvalid <= 1'b0;
        hs(1);
        chk("bresp", r, o_bresp);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        hs(2);
        i_arvalid <= 1'b0;
        hs(3);
        chk("rdata", d, o_rdata);
        chk("rresp", r, o_rresp);
    endtask
    // one sample, then settle past the scaler
    task automatic smp(input logic [15:0] lp, input logic [15:0] fu);
        val <= {lp, fu};
        go <= 1'b1;
        @(posedge i_clk_sys);
        go <= 1'b0;
        repeat (20) @(posedge i_clk_sys);
    endtask
    // hysteresis with zero hold and delay
    function automatic logic swx(input logic s, input logic signed [15:0] x);
        return s ? x >= 16'sh0320 : x > 16'sh03E8;
    endfunction
    // ==========
    // main sequence
    initial begin
        repeat (6) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        @(posedge i_clk_sys);
        rd(`OFS_CUTOFF, 32'h0000_0190, OK);
        wr(`OFS_CUTOFF, 32'h0000_001D, ER);
        wr(`OFS_CUTOFF, 32'h0000_0191, ER);
        wr(`OFS_CUTOFF, 32'h0000_001E, OK);
        // no byte enabled: accepted, nothing written
        i_wstrb <= 4'h0;
        wr(`OFS_CUTOFF, 32'h0000_0100, OK);
        i_wstrb <= 4'hF;
        rd(`OFS_CUTOFF, 32'h0000_001E, OK);
        v = 16'({$random(seed)} % 101);
        wr(`OFS_GYRO, {16'h0000, v}, OK);
        wr(`OFS_GYRO, 32'h0000_0065, ER);
        rd(`OFS_GYRO, {16'h0000, v}, OK);
        chk("filt_cfg", {16'h001E, v}, o_filt_cfg);
        $display("filter done");
        wr(`OFS_RSTART, 32'h0000_0001, ER);
        wr(`OFS_RSTART, 32'h0000_FF9C, OK);
        wr(`OFS_REND, 32'h0000_FF38, ER);
        wr(`OFS_REND, 32'h0000_0000, OK);
        rd(8'h34, 32'h0000_0000, ER);
        // sticky refusal flag, then write one to clear
        rd(`OFS_STATUS, 32'h0000_0002, OK);
        wr(`OFS_STATUS, 32'h0000_0002, OK);
        rd(`OFS_STATUS, 32'h0000_0000, OK);
        $display("range done");
        // every output type, low-pass source
        for (int t = 0; t < 4; t++) begin
            wr(`OFS_CTRL, t, OK);
            smp(16'h0000, 16'hFF9C);
            chk("aout", (t == 1 || t == 2) ? 32'h0000_FFFF : 32'h0000_0000, o_aout_code);
            chk("out_type", t, o_out_type);
        end
        wr(`OFS_CTRL, 32'h0000_0006, OK);
        smp(16'h0000, 16'hFF9C);
        chk("aout", 32'h0000_0000, o_aout_code);
        $display("analog done");
        wr(`OFS_THR_A, 32'h0000_03E8, OK);
        wr(`OFS_THR_B, 32'h0000_0320, OK);
        wr(`OFS_CTRL, 32'h0000_0003, OK);
        for (int i = 0; i < 12; i++) begin
            v = (i < 4) ? CORNER[i] : 16'sh0320 + 16'($random(seed) % 1500);
            smp(v, 16'h0000);
            st = swx(st, v);
            chk("switch", st, o_switch);
        end
        // start idle so the hold is loaded afresh
        smp(16'h0000, 16'h0000);
        // one tick of hold, then one tick of delay
        for (int k = 0; k < 2; k++) begin
            wr(k ? `OFS_DELAY : `OFS_HOLD, 32'h0000_0001, OK);
            wr(k ? `OFS_HOLD : `OFS_DELAY, 32'h0000_0000, OK);
            smp(16'h05DC, 16'h0000);
            smp(16'h0000, 16'h0000);
            chk("switch", 32'h0000_0001, o_switch);
            repeat (5000) @(posedge i_clk_sys);
            smp(16'h0000, 16'h0000);
            chk("switch", 32'h0000_0000, o_switch);
        end
        $display("switch done");
        smp(16'h01F4, 16'hFFC9);
        rd(`OFS_LP_VAL, 32'h0000_01F4, OK);
        rd(`OFS_FUS_VAL, 32'h0000_FFC9, OK);
        wr(`OFS_CTRL, 32'h0000_000B, OK);
        rd(`OFS_OFFSET, 32'h0000_01F4, OK);
        smp(16'h0578, 16'h0000);
        chk("switch", 32'h0000_0000, o_switch);
        smp(16'h05DD, 16'h0000);
        chk("switch", 32'h0000_0001, o_switch);
        $display("zero done");
        final_report();
    end
endmodule
